// ===== common/mbc_pkg.sv
// package for the microcore branch and count-limit decoder
// assumes a decoded instruction struct, 16-bit count limits and a 10-bit code address
package mbc_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	// register byte offsets (printed offsets are not word multiples: index times four)
	localparam logic [11:0] IDX_CORE0_STAT_A = 12'h101;
	localparam logic [11:0] IDX_CORE0_STAT_B = 12'h102;
	localparam logic [11:0] IDX_CORE1_STAT_A = 12'h121;
	localparam logic [11:0] IDX_CORE1_STAT_B = 12'h122;
	localparam logic [13:0] ADR_CORE0_STAT_A = {IDX_CORE0_STAT_A, 2'h0};
	localparam logic [13:0] ADR_CORE0_STAT_B = {IDX_CORE0_STAT_B, 2'h0};
	localparam logic [13:0] ADR_CORE1_STAT_A = {IDX_CORE1_STAT_A, 2'h0};
	localparam logic [13:0] ADR_CORE1_STAT_B = {IDX_CORE1_STAT_B, 2'h0};
	localparam logic [13:0] ADR_STATE = 14'h0600;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// opcodes
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_JUMP_FAR_STATUS = 3'h1,
		OP_JUMP_REL_STATUS = 3'h2,
		OP_CALL_FAR = 3'h3,
		OP_CALL_REL = 3'h4,
		OP_LOAD_LIMIT = 3'h5
	} mbc_op_t;
	// shortcut actions
	localparam logic [1:0] SC_KEEP = 2'h0;
	localparam logic [1:0] SC_OFF = 2'h1;
	localparam logic [1:0] SC_ON = 2'h2;
	localparam logic [1:0] SC_TOGGLE = 2'h3;
	typedef struct packed {
		mbc_op_t op;
		logic [ADDR_W-1:0] pc;
		logic [3:0] status_bit_selector;
		logic polarity;
		logic register_operand;
		logic [4:0] offset;
		logic [1:0] first_output_shortcut;
		logic [1:0] second_output_shortcut;
		logic [1:0] limit_sel;
		logic clear_counter;
		logic core_sel;
		logic status_sel;
		logic [CNT_W-1:0] alu_value;
	} mbc_instr_t;
	typedef struct packed {
		logic [1:0] htrans;
		logic [31:0] haddr;
		logic hwrite;
		logic [2:0] hsize;
		logic [DATA_W-1:0] hwdata;
		logic hsel;
	} mbc_ahb_req_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1
	} mbc_state_t;
endpackage : mbc_pkg

// ===== core/mbc_decoder.sv
// microcore branch, call and count-limit load execution unit
// assumes one decoded instruction per INSTR_VALID pulse and an AHB-Lite master
`timescale 1ns/1ps
module mbc_decoder
	import mbc_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// decoded instruction
	input wire logic INSTR_VALID,
	input wire mbc_pkg::mbc_instr_t INSTR,
	// jump register loads
	input wire logic JUMP_LOAD_ONE,
	input wire logic JUMP_LOAD_TWO,
	input wire logic [mbc_pkg::ADDR_W-1:0] JUMP_LOAD_VALUE,
	// counters run internally; each COUNT_TICK bit increments its own count
	input wire logic [3:0] COUNT_TICK,
	// register bus
	input wire mbc_pkg::mbc_ahb_req_t AHB_REQ,
	input wire logic HREADY,
	output logic [mbc_pkg::DATA_W-1:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// program flow
	output logic [mbc_pkg::ADDR_W-1:0] PROGRAM_COUNTER,
	output logic [mbc_pkg::ADDR_W-1:0] AUX_REG,
	output logic BRANCH_TAKEN,
	// counters and shortcuts
	output logic [4*mbc_pkg::CNT_W-1:0] COUNT_LIMITS,
	output logic [4*mbc_pkg::CNT_W-1:0] COUNT_VALUES,
	output logic DIAG_GROUP_ONE,
	output logic DIAG_GROUP_TWO
);
	import mbc_pkg::*;

	// ==========================================================
	// state
	logic [ADDR_W-1:0] pc_reg, pc_next, aux_reg, aux_next;
	logic [ADDR_W-1:0] jump_target_one_reg, jump_target_one_next;
	logic [ADDR_W-1:0] jump_target_two_reg, jump_target_two_next;
	logic taken_reg, taken_next;
	logic [CNT_W-1:0] limit_reg [4];
	logic [CNT_W-1:0] limit_next [4];
	logic [CNT_W-1:0] count_reg [4];
	logic [CNT_W-1:0] count_next [4];
	logic diag1_reg, diag1_next, diag2_reg, diag2_next;
	logic [15:0] stat_reg [4];
	logic [15:0] stat_next [4];
	// bus
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic wr_pend_reg, wr_pend_next;
	logic [1:0] wr_idx_reg, wr_idx_next;
	logic wr_hit_reg, wr_hit_next;
	mbc_state_t st_reg, st_next;
	logic ready_reg, ready_next;
	logic err_reg, err_next;

	// ==========================================================
	// decode helpers
	logic [15:0] status_word;
	logic sel_bit, cond_true;
	logic [ADDR_W-1:0] rel_target, far_target, seq_pc;
	logic [1:0] stat_idx;

	function automatic logic sc_apply(input logic cur, input logic [1:0] code);
		logic r;
		r = cur;
		unique case (code)
			SC_KEEP: r = cur;
			SC_OFF: r = 1'b0;
			SC_ON: r = 1'b1;
			SC_TOGGLE: r = ~cur;
		endcase
		return r;
	endfunction : sc_apply

	always_comb begin
		// core select and register select pick one of four status words
		stat_idx = {INSTR.core_sel, INSTR.status_sel};
		status_word = stat_reg[stat_idx];
		sel_bit = status_word[INSTR.status_bit_selector];
		cond_true = (sel_bit == INSTR.polarity);
		// wraps modulo code space on purpose
		rel_target = ADDR_W'(INSTR.pc + {{(ADDR_W-5){INSTR.offset[4]}}, INSTR.offset});
		// register operand zero names jump target one
		far_target = INSTR.register_operand ? jump_target_two_reg : jump_target_one_reg;
		seq_pc = ADDR_W'(INSTR.pc + ADDR_W'(1));
	end

	// ==========================================================
	// program flow
	always_comb begin
		pc_next = pc_reg;
		aux_next = aux_reg;
		taken_next = 1'b0;
		// a jump register loaded in the cycle of a far jump counts from the next one
		jump_target_one_next = JUMP_LOAD_ONE ? JUMP_LOAD_VALUE : jump_target_one_reg;
		jump_target_two_next = JUMP_LOAD_TWO ? JUMP_LOAD_VALUE : jump_target_two_reg;
		if (INSTR_VALID) begin
			pc_next = seq_pc;
			unique case (INSTR.op)
				OP_JUMP_FAR_STATUS: begin
					if (cond_true) begin
						pc_next = far_target;
						taken_next = 1'b1;
					end
				end
				OP_JUMP_REL_STATUS: begin
					if (cond_true) begin
						pc_next = rel_target;
						taken_next = 1'b1;
					end
				end
				OP_CALL_FAR: begin
					aux_next = INSTR.pc;
					pc_next = far_target;
					taken_next = 1'b1;
				end
				OP_CALL_REL: begin
					aux_next = INSTR.pc;
					pc_next = rel_target;
					taken_next = 1'b1;
				end
				default: begin
					pc_next = seq_pc;
				end
			endcase
		end
	end

	// ==========================================================
	// count limits and shortcuts
	logic do_load;
	assign do_load = INSTR_VALID && (INSTR.op == OP_LOAD_LIMIT);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cnt
			always_comb begin
				limit_next[g] = limit_reg[g];
				// a clearing load beats a tick in the same cycle
				count_next[g] = COUNT_TICK[g] ? CNT_W'(count_reg[g] + CNT_W'(1)) : count_reg[g];
				if (do_load && (INSTR.limit_sel == 2'(g))) begin
					limit_next[g] = INSTR.alu_value;
					if (INSTR.clear_counter) begin
						count_next[g] = '0;
					end
				end
			end
			always_ff @(posedge CLK_SYS) begin
				if (SRST) begin
					limit_reg[g] <= '0;
					count_reg[g] <= '0;
				end else begin
					limit_reg[g] <= limit_next[g];
					count_reg[g] <= count_next[g];
				end
			end
		end
	endgenerate

	always_comb begin
		diag1_next = do_load ? sc_apply(diag1_reg, INSTR.first_output_shortcut) : diag1_reg;
		diag2_next = do_load ? sc_apply(diag2_reg, INSTR.second_output_shortcut) : diag2_reg;
	end

	// ==========================================================
	// AHB-Lite slave: zero wait, writes land one cycle after the address phase
	// decode codes: low two bits index the status words
	localparam logic [2:0] HIT_NONE = 3'h4;
	localparam logic [2:0] HIT_STATE = 3'h5;
	function automatic logic [2:0] map_addr(input logic [31:0] a);
		logic [2:0] r;
		r = HIT_NONE;
		unique case (a[13:0])
			ADR_CORE0_STAT_A: r = 3'h0;
			ADR_CORE0_STAT_B: r = 3'h1;
			ADR_CORE1_STAT_A: r = 3'h2;
			ADR_CORE1_STAT_B: r = 3'h3;
			ADR_STATE: r = HIT_STATE;
			default: r = HIT_NONE;
		endcase
		if (a[31:14] != '0) begin
			r = HIT_NONE;
		end
		return r;
	endfunction : map_addr

	logic addr_ok;
	logic [2:0] hit;
	always_comb begin
		addr_ok = AHB_REQ.hsel && HREADY && (AHB_REQ.htrans == HTRANS_NONSEQ);
		hit = map_addr(AHB_REQ.haddr);
		rdata_next = rdata_reg;
		wr_pend_next = 1'b0;
		wr_idx_next = wr_idx_reg;
		wr_hit_next = 1'b0;
		st_next = addr_ok ? ST_EXEC : ST_IDLE;
		// zero wait and always OKAY, yet kept in flops so no output is combinational
		ready_next = 1'b1;
		err_next = 1'b0;
		for (int i = 0; i < 4; i++) begin
			stat_next[i] = stat_reg[i];
		end
		// the write lands in its data phase, one cycle after the address was taken
		if ((st_reg == ST_EXEC) && wr_pend_reg && wr_hit_reg) begin
			stat_next[wr_idx_reg] = AHB_REQ.hwdata[15:0];
		end
		if (addr_ok) begin
			wr_pend_next = AHB_REQ.hwrite;
			wr_idx_next = hit[1:0];
			wr_hit_next = (hit[2] == 1'b0);
			if (!AHB_REQ.hwrite) begin
				unique case (hit)
					3'h0, 3'h1, 3'h2, 3'h3: rdata_next = {16'h0000, stat_reg[hit[1:0]]};
					HIT_STATE: rdata_next = {6'h00, aux_reg, 6'h00, pc_reg};
					default: rdata_next = 32'h0000_0000;
				endcase
				// a read right behind a write to the same register sees the new word
				if (wr_pend_reg && wr_hit_reg && !hit[2] && (wr_idx_reg == hit[1:0])) begin
					rdata_next = {16'h0000, AHB_REQ.hwdata[15:0]};
				end
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			pc_reg <= '0;
			aux_reg <= '0;
			taken_reg <= 1'b0;
			jump_target_one_reg <= '0;
			jump_target_two_reg <= '0;
			diag1_reg <= 1'b0;
			diag2_reg <= 1'b0;
			rdata_reg <= '0;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= '0;
			wr_hit_reg <= 1'b0;
			st_reg <= ST_IDLE;
			ready_reg <= 1'b1;
			err_reg <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				stat_reg[i] <= STAT_RESET;
			end
		end else begin
			pc_reg <= pc_next;
			aux_reg <= aux_next;
			taken_reg <= taken_next;
			jump_target_one_reg <= jump_target_one_next;
			jump_target_two_reg <= jump_target_two_next;
			diag1_reg <= diag1_next;
			diag2_reg <= diag2_next;
			rdata_reg <= rdata_next;
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			wr_hit_reg <= wr_hit_next;
			st_reg <= st_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
			for (int i = 0; i < 4; i++) begin
				stat_reg[i] <= stat_next[i];
			end
		end
	end

	// ==========================================================
	// outputs, all from flip-flops
	always_comb begin
		PROGRAM_COUNTER = pc_reg;
		AUX_REG = aux_reg;
		BRANCH_TAKEN = taken_reg;
		DIAG_GROUP_ONE = diag1_reg;
		DIAG_GROUP_TWO = diag2_reg;
		HRDATA = rdata_reg;
		HREADYOUT = ready_reg;
		HRESP = err_reg;
		for (int i = 0; i < 4; i++) begin
			COUNT_LIMITS[i*CNT_W +: CNT_W] = limit_reg[i];
			COUNT_VALUES[i*CNT_W +: CNT_W] = count_reg[i];
		end
	end
endmodule : mbc_decoder

// ===== tb/mbc_checker.sv
// checker for mbc_decoder, bound to its ports
// assumes clock CLK_SYS and the synchronous reset SRST
`timescale 1ns/1ps
module mbc_checker
	import mbc_pkg::*;
(
	// watched ports
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic INSTR_VALID,
	input wire mbc_pkg::mbc_instr_t INSTR,
	input wire logic JUMP_LOAD_ONE,
	input wire logic JUMP_LOAD_TWO,
	input wire logic [mbc_pkg::ADDR_W-1:0] JUMP_LOAD_VALUE,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic [mbc_pkg::ADDR_W-1:0] PROGRAM_COUNTER,
	input wire logic [mbc_pkg::ADDR_W-1:0] AUX_REG,
	input wire logic BRANCH_TAKEN,
	input wire logic [4*mbc_pkg::CNT_W-1:0] COUNT_LIMITS,
	input wire logic [4*mbc_pkg::CNT_W-1:0] COUNT_VALUES,
	input wire logic DIAG_GROUP_TWO
);
	// ======
	// jump register shadow
	logic [ADDR_W-1:0] jr_reg [2];
	logic [ADDR_W-1:0] jr_next [2];
	always_comb begin
		jr_next = jr_reg;
		if (JUMP_LOAD_ONE) jr_next[0] = JUMP_LOAD_VALUE;
		if (JUMP_LOAD_TWO) jr_next[1] = JUMP_LOAD_VALUE;
	end
	always_ff @(posedge CLK_SYS) jr_reg <= jr_next;
	wire logic [ADDR_W-1:0] far_t = jr_reg[INSTR.register_operand];
	wire logic [ADDR_W-1:0] rel_t = INSTR.pc + {{5{INSTR.offset[4]}}, INSTR.offset};
	wire logic [ADDR_W-1:0] seq_t = INSTR.pc + 10'h1;
	wire logic ld = INSTR_VALID && INSTR.op == OP_LOAD_LIMIT;
	// ======
	// properties
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
	rel_call_a: assert property (INSTR_VALID && INSTR.op == OP_CALL_REL |=> PROGRAM_COUNTER == $past(rel_t)
		&& AUX_REG == $past(INSTR.pc)) else $error("relative call wrong");
	far_call_a: assert property (INSTR_VALID && INSTR.op == OP_CALL_FAR |=> PROGRAM_COUNTER == $past(far_t)
		&& BRANCH_TAKEN) else $error("far call wrong");
	plain_step_a: assert property (INSTR_VALID && INSTR.op == OP_NONE |=> PROGRAM_COUNTER == $past(seq_t)
		&& !BRANCH_TAKEN) else $error("plain step wrong");
	limit_load_a: assert property (ld |=> COUNT_LIMITS[$past(INSTR.limit_sel)*16 +: 16] == $past(INSTR.alu_value))
		else $error("limit not loaded");
	count_clear_a: assert property (ld && INSTR.clear_counter |=> COUNT_VALUES[$past(INSTR.limit_sel)*16 +: 16] == '0)
		else $error("counter not cleared");
	diag_flip_a: assert property (ld && INSTR.second_output_shortcut == SC_TOGGLE |=> $changed(DIAG_GROUP_TWO))
		else $error("toggle did not invert");
	flow_hold_a: assert property (!INSTR_VALID |=> $stable(PROGRAM_COUNTER) && $stable(AUX_REG) && !BRANCH_TAKEN)
		else $error("flow moved without instruction");
	rel_call_c: cover property (INSTR_VALID && INSTR.op == OP_CALL_REL);
	clear_c: cover property (ld && INSTR.clear_counter);
	taken_c: cover property (BRANCH_TAKEN);
endmodule : mbc_checker
bind mbc_decoder mbc_checker mbc_checker_i (.*);

// ===== tb/test_microcore_branch_and_counter_load.sv
// testbench for mbc_decoder: status registers, random instruction stream
// assumes the checker is bound to the decoder
`timescale 1ns/1ps
module test_microcore_branch_and_counter_load;
	import mbc_pkg::*;
	// ======
	// ports and shadows
	logic CLK_SYS = 0, SRST = 1, INSTR_VALID = 0, JUMP_LOAD_ONE = 0, JUMP_LOAD_TWO = 0, vd = 0, d1 = 0, d2 = 0;
	mbc_instr_t INSTR = '0;
	mbc_ahb_req_t AHB_REQ = '0;
	logic [ADDR_W-1:0] JUMP_LOAD_VALUE = '0, PROGRAM_COUNTER, AUX_REG, pc_e = '0, aux_e = '0;
	logic [3:0] COUNT_TICK = '0;
	logic [DATA_W-1:0] HRDATA;
	logic HREADYOUT, HRESP, BRANCH_TAKEN, DIAG_GROUP_ONE, DIAG_GROUP_TWO;
	logic [3:0][CNT_W-1:0] COUNT_LIMITS, COUNT_VALUES, lim = '0, cnt = '0;
	logic [15:0] stat [4] = '{default: '0};
	logic [ADDR_W-1:0] jr [2];
	logic [150:0] q [$];
	logic [31:0] rq [$];
	logic rv = 0;
	int num_errors = 0, n_checks = 0, cyc = 0;
	always #4 CLK_SYS = ~CLK_SYS;
	mbc_decoder mbc_decoder_i (.HREADY(HREADYOUT), .*);
	// ======
	// checking and timeout
	task check(input logic [150:0] s, e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task wrap_up();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	always @(posedge CLK_SYS) begin
		vd <= INSTR_VALID;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			wrap_up();
		end
	end
	// results land one cycle after the instruction edge; sampled mid-cycle to stay clear of it
	always @(negedge CLK_SYS) if (vd) check({PROGRAM_COUNTER, AUX_REG, BRANCH_TAKEN, DIAG_GROUP_ONE, DIAG_GROUP_TWO,
		COUNT_LIMITS, COUNT_VALUES}, q.pop_front());
	// read data is taken at the edge that closes the data phase
	always @(posedge CLK_SYS) if (rv) check(HRDATA, rq.pop_front());
	// ======
	// drivers
	task bus(input logic w, input logic [31:0] a, d);
		AHB_REQ <= '{HTRANS_NONSEQ, a, w, HSIZE_WORD, AHB_REQ.hwdata, 1'b1};
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		AHB_REQ.htrans <= 2'h0;
		AHB_REQ.hwdata <= d;
		rv <= !w;
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		rv <= 1'b0;
	endtask : bus
	function automatic logic [31:0] adr(input int k);
		logic [13:0] t [5] = '{ADR_CORE0_STAT_A, ADR_CORE0_STAT_B, ADR_CORE1_STAT_A, ADR_CORE1_STAT_B, 14'h0010};
		return {18'h0, t[k]};
	endfunction : adr
	function automatic logic sc(input logic v, input logic [1:0] c);
		return c == SC_KEEP ? v : c == SC_TOGGLE ? !v : c == SC_ON;
	endfunction : sc
	task ldj();
		for (int k = 0; k < 2; k++) begin
			jr[k] = ADDR_W'($urandom);
			JUMP_LOAD_VALUE <= jr[k];
			JUMP_LOAD_ONE <= k == 0;
			JUMP_LOAD_TWO <= k == 1;
			@(posedge CLK_SYS);
		end
		JUMP_LOAD_TWO <= 0;
	endtask : ldj
	task ex();
		mbc_instr_t in;
		logic [3:0] tk;
		logic [ADDR_W-1:0] rel;
		logic hit, tb;
		in = ($bits(mbc_instr_t))'({$urandom, $urandom});
		in.op = mbc_op_t'($urandom_range(5));
		tk = 4'($urandom);
		rel = in.pc + {{5{in.offset[4]}}, in.offset};
		hit = stat[{in.core_sel, in.status_sel}][in.status_bit_selector] == in.polarity;
		tb = in.op inside {OP_CALL_FAR, OP_CALL_REL} || hit && in.op inside {OP_JUMP_FAR_STATUS, OP_JUMP_REL_STATUS};
		pc_e = in.pc + 10'h1;
		if (tb) pc_e = in.op inside {OP_JUMP_FAR_STATUS, OP_CALL_FAR} ? jr[in.register_operand] : rel;
		if (in.op inside {OP_CALL_FAR, OP_CALL_REL}) aux_e = in.pc;
		for (int k = 0; k < 4; k++) cnt[k] = cnt[k] + tk[k];
		if (in.op == OP_LOAD_LIMIT) begin
			lim[in.limit_sel] = in.alu_value;
			if (in.clear_counter) cnt[in.limit_sel] = '0;
			d1 = sc(d1, in.first_output_shortcut);
			d2 = sc(d2, in.second_output_shortcut);
		end
		q.push_back({pc_e, aux_e, tb, d1, d2, lim, cnt});
		INSTR <= in;
		INSTR_VALID <= 1;
		COUNT_TICK <= tk;
		@(posedge CLK_SYS);
	endtask : ex
	// ======
	// main sequence
	initial begin
		logic [31:0] r, v;
		r = $urandom(32'h819C);
		repeat (6) @(posedge CLK_SYS);
		SRST <= 0;
		@(posedge CLK_SYS);
		for (int k = 0; k < 5; k++) begin
			v = $urandom;
			rq.push_back(STAT_RESET);
			bus(0, adr(k), 32'h0);
			bus(1, adr(k), v);
			if (k < 4) stat[k] = v[15:0];
			rq.push_back(k < 4 ? {16'h0, v[15:0]} : 32'h0);
			bus(0, adr(k), 32'h0);
		end
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			ldj();
			repeat (150) ex();
			INSTR_VALID <= 0;
			COUNT_TICK <= 4'h0;
			@(posedge CLK_SYS);
		end
		$display("test instructions done");
		rq.push_back({6'h0, aux_e, 6'h0, pc_e});
		bus(0, {18'h0, ADR_STATE}, 32'h0);
		$display("test state read done");
		repeat (2) @(posedge CLK_SYS);
		wrap_up();
	end
endmodule : test_microcore_branch_and_counter_load
